// ===== hw/timer_two_pkg.sv
package timer_two_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'h04;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h08;
  localparam logic [7:0] ADDR_COUNT = 8'h0C;
  localparam logic [7:0] ADDR_MODE = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;

  // ----------------------------------------------------------------
  // Control register fields, plus the mode register's up/down enable bit
  // ----------------------------------------------------------------
  localparam int BIT_OVERFLOW_FLAG = 7;
  localparam int BIT_EXTERNAL_EVENT_FLAG = 6;
  localparam int BIT_RX_BAUD_SOURCE = 5;
  localparam int BIT_TX_BAUD_SOURCE = 4;
  localparam int BIT_EXTERNAL_TRIGGER_ENABLE = 3;
  localparam int BIT_RUN_CONTROL = 2;
  localparam int BIT_COUNT_SOURCE = 1;
  localparam int BIT_CAPTURE_RELOAD = 0;
  localparam int BIT_UP_DOWN_ENABLE = 0;

  // Interrupt status and mask fields
  localparam int BIT_IRQ_OVERFLOW = 0;
  localparam int BIT_IRQ_EXTERNAL = 1;

  // ----------------------------------------------------------------
  // Reset values and the all-ones count limit
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_CONTROL = 8'h00;
  localparam logic [15:0] RESET_RELOAD = 16'h0000;
  localparam logic [15:0] RESET_COUNT = 16'h0000;
  localparam logic [1:0] RESET_IRQ = 2'h0;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;

  // Serial modes that take a baud clock from a timer
  localparam logic [1:0] SERIAL_MODE_ONE = 2'h1;
  localparam logic [1:0] SERIAL_MODE_THREE = 2'h3;

  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Internal tick prescale in system clocks
  localparam int TICK_DIVIDE_DEFAULT = 12;

endpackage : timer_two_pkg

// ===== hw/timer_two_control_logic.sv
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module timer_two_control_logic
  import timer_two_pkg::*;
#(
  parameter int TICK_DIVIDE = TICK_DIVIDE_DEFAULT
) (
  input wire logic CLOCK,
  input wire logic RESET_N,
  // AXI4-Lite slave
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Pins and neighbours
  input wire logic TRIGGER_INPUT,
  input wire logic EVENT_INPUT,
  input wire logic TIMER1_OVERFLOW,
  input wire logic [1:0] SERIAL_MODE,
  output logic RX_BAUD_TICK,
  output logic TX_BAUD_TICK,
  output logic TIMER_INT_REQ,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Merge one byte lane of a write into a stored byte
  function automatic logic [7:0] lane_merge(input logic [7:0] old_val, input logic [7:0] new_val,
                                            input logic strobe);
    lane_merge = strobe ? new_val : old_val;
  endfunction : lane_merge

  // Falling edge seen between two samples
  function automatic logic fell(input logic prev_val, input logic now_val);
    fell = prev_val & ~now_val;
  endfunction : fell

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Each group is computed in one comb block and registered in one clocked block
  // The mode register holds only the up/down enable; counting itself is up only
  logic [7:0] control_reg, control_next;
  logic [15:0] reload_reg, reload_next;
  logic [15:0] count_reg, count_next;
  logic mode_reg, mode_next;
  logic [1:0] irq_status_reg, irq_status_next;
  logic [1:0] irq_mask_reg, irq_mask_next;
  logic [2:0] trig_sync_reg, trig_sync_next;
  logic [2:0] event_sync_reg, event_sync_next;
  logic [7:0] div_reg, div_next;
  logic ovf_pulse_reg, ovf_pulse_next;
  logic aw_full_reg, aw_full_next;
  logic [7:0] aw_addr_reg, aw_addr_next;
  logic w_full_reg, w_full_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;

  // Decoded conditions, all derived from registered state
  logic baud_mode;
  logic trig_edge;
  logic trig_event;
  logic count_pulse;
  logic tick;
  logic do_write;
  logic wr_hit;
  logic overflow;

  // ----------------------------------------------------------------
  // Decoding of control fields
  // ----------------------------------------------------------------
  // Either baud source bit puts the timer into baud-generator duty
  assign baud_mode = control_reg[BIT_RX_BAUD_SOURCE] | control_reg[BIT_TX_BAUD_SOURCE];
  assign trig_edge = fell(trig_sync_reg[2], trig_sync_reg[1]);
  // Baud duty blocks trigger actions, since the reload value then sets the bit rate
  // Trigger qualification
  assign trig_event = trig_edge & control_reg[BIT_EXTERNAL_TRIGGER_ENABLE] & ~baud_mode;
  // Prescaler strobe: one cycle in every TICK_DIVIDE
  assign tick = (div_reg == 8'(TICK_DIVIDE - 1));
  assign count_pulse = control_reg[BIT_RUN_CONTROL] &
                       (control_reg[BIT_COUNT_SOURCE] ? fell(event_sync_reg[2], event_sync_reg[1]) : tick);
  // Overflow is the step out of the all-ones count
  assign overflow = count_pulse & (count_reg == COUNT_MAX);
  // A write runs once both halves are held and the last answer has gone
  assign do_write = aw_full_reg & w_full_reg & ~bvalid_reg;

  // ----------------------------------------------------------------
  // Synchronisers and prescaler
  // ----------------------------------------------------------------
  // Stage 0 feeds only stage 1; edges are judged on stages 1 and 2
  always_comb begin
    trig_sync_next = {trig_sync_reg[1:0], TRIGGER_INPUT};
    event_sync_next = {event_sync_reg[1:0], EVENT_INPUT};
    div_next = tick ? 8'h00 : 8'(div_reg + 8'h01);
  end

  // Chains reset high, so a pin idling high when reset ends gives no false edge; a pin already low gives one edge
  // Limitation: a pin pulse shorter than one clock may pass unseen
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      trig_sync_reg <= 3'h7;
      event_sync_reg <= 3'h7;
      div_reg <= 8'h00;
    end else begin
      trig_sync_reg <= trig_sync_next;
      event_sync_reg <= event_sync_next;
      div_reg <= div_next;
    end
  end

  // ----------------------------------------------------------------
  // Timer core and registers
  // ----------------------------------------------------------------
  // Hardware sets win over software clears in the same cycle
  always_comb begin
    control_next = control_reg;
    reload_next = reload_reg;
    count_next = count_reg;
    mode_next = mode_reg;
    irq_status_next = irq_status_reg;
    irq_mask_next = irq_mask_reg;
    ovf_pulse_next = 1'b0;
    wr_hit = 1'b1;
    // Software writes first, hardware afterwards overrides
    if (do_write) begin
      case (aw_addr_reg)
        ADDR_CONTROL: begin
          control_next = lane_merge(control_reg, w_data_reg[7:0], w_strb_reg[0]);
        end
        ADDR_RELOAD_LOW: begin
          reload_next[7:0] = lane_merge(reload_reg[7:0], w_data_reg[7:0], w_strb_reg[0]);
        end
        ADDR_RELOAD_HIGH: begin
          reload_next[15:8] = lane_merge(reload_reg[15:8], w_data_reg[7:0], w_strb_reg[0]);
        end
        ADDR_COUNT: begin
          count_next[7:0] = lane_merge(count_reg[7:0], w_data_reg[7:0], w_strb_reg[0]);
          count_next[15:8] = lane_merge(count_reg[15:8], w_data_reg[15:8], w_strb_reg[1]);
        end
        ADDR_MODE: begin
          if (w_strb_reg[0]) begin
            mode_next = w_data_reg[BIT_UP_DOWN_ENABLE];
          end
        end
        ADDR_IRQ_STATUS: begin
          if (w_strb_reg[0]) begin
            irq_status_next = irq_status_reg & ~w_data_reg[1:0];
          end
        end
        ADDR_IRQ_MASK: begin
          if (w_strb_reg[0]) begin
            irq_mask_next = w_data_reg[1:0];
          end
        end
        // Unmapped offsets change nothing and answer with an error
        default: begin
          wr_hit = 1'b0;
        end
      endcase
    end
    // A counter step beats a software count write landing in the same cycle
    // Counting
    if (count_pulse) begin
      count_next = 16'(count_reg + 16'h0001);
    end
    // Overflow: raise the event, then choose reload or wrap
    if (overflow) begin
      ovf_pulse_next = 1'b1;
      irq_status_next[BIT_IRQ_OVERFLOW] = 1'b1;
      if (baud_mode || !control_reg[BIT_CAPTURE_RELOAD]) begin
        count_next = reload_reg;
      end
      if (!baud_mode) begin
        control_next[BIT_OVERFLOW_FLAG] = 1'b1;
      end
    end
    // Trigger edge: capture or reload, beats a same-cycle bus write
    if (trig_event) begin
      if (control_reg[BIT_CAPTURE_RELOAD]) begin
        // Capture copies the count as it stood before this cycle's step
        // Capture into reload pair
        reload_next = count_reg;
      end else begin
        count_next = reload_reg;
      end
      control_next[BIT_EXTERNAL_EVENT_FLAG] = 1'b1;
      irq_status_next[BIT_IRQ_EXTERNAL] = 1'b1;
    end
  end

  // Timer state and registers, cleared by the synchronous reset
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      control_reg <= RESET_CONTROL;
      reload_reg <= RESET_RELOAD;
      count_reg <= RESET_COUNT;
      mode_reg <= 1'b0;
      irq_status_reg <= RESET_IRQ;
      irq_mask_reg <= RESET_IRQ;
      ovf_pulse_reg <= 1'b0;
    end else begin
      control_reg <= control_next;
      reload_reg <= reload_next;
      count_reg <= count_next;
      mode_reg <= mode_next;
      irq_status_reg <= irq_status_next;
      irq_mask_reg <= irq_mask_next;
      ovf_pulse_reg <= ovf_pulse_next;
    end
  end

  // ----------------------------------------------------------------
  // Serial baud clock steering
  // ----------------------------------------------------------------
  // Ticks only matter in the variable-rate serial modes
  logic timer_baud_mode;
  assign timer_baud_mode = (SERIAL_MODE == SERIAL_MODE_ONE) || (SERIAL_MODE == SERIAL_MODE_THREE);

  // Timer ticks leave one cycle after the overflow, from a flip-flop
  // Receive source
  assign RX_BAUD_TICK = timer_baud_mode &
                        (control_reg[BIT_RX_BAUD_SOURCE] ? ovf_pulse_reg : TIMER1_OVERFLOW);
  assign TX_BAUD_TICK = timer_baud_mode &
                        (control_reg[BIT_TX_BAUD_SOURCE] ? ovf_pulse_reg : TIMER1_OVERFLOW);

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // Request from the overflow flag and the external event flag gated by mode_reg
  assign TIMER_INT_REQ = control_reg[BIT_OVERFLOW_FLAG] |
                         (control_reg[BIT_EXTERNAL_EVENT_FLAG] & ~mode_reg);
  // Bus-side request: status events that software left unmasked
  assign IRQ = |(irq_status_reg & irq_mask_reg);

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  // Address and data are held separately so they may come in any order
  always_comb begin
    aw_full_next = aw_full_reg;
    aw_addr_next = aw_addr_reg;
    w_full_next = w_full_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_full_next = 1'b1;
      aw_addr_next = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_full_next = 1'b1;
      w_data_next = S_AXI_WDATA;
      w_strb_next = S_AXI_WSTRB;
    end
    if (do_write) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_reg && S_AXI_BREADY) begin
      bvalid_next = 1'b0;
    end
    // Read data are sampled when the address is taken; later updates are not seen
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      case (S_AXI_ARADDR)
        ADDR_CONTROL: rdata_next = {24'h000000, control_reg};
        ADDR_RELOAD_LOW: rdata_next = {24'h000000, reload_reg[7:0]};
        ADDR_RELOAD_HIGH: rdata_next = {24'h000000, reload_reg[15:8]};
        ADDR_COUNT: rdata_next = {16'h0000, count_reg};
        ADDR_MODE: rdata_next = {31'h00000000, mode_reg};
        ADDR_IRQ_STATUS: rdata_next = {30'h00000000, irq_status_reg};
        ADDR_IRQ_MASK: rdata_next = {30'h00000000, irq_mask_reg};
        default: begin
          rdata_next = 32'h00000000;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && S_AXI_RREADY) begin
      rvalid_next = 1'b0;
    end
  end

  // Bus holding slots and answers
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_full_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= RESP_OKAY;
    end else begin
      aw_full_reg <= aw_full_next;
      aw_addr_reg <= aw_addr_next;
      w_full_reg <= w_full_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // Ready while the holding slot is empty and no response waits
  assign S_AXI_AWREADY = ~aw_full_reg & ~bvalid_reg;
  assign S_AXI_WREADY = ~w_full_reg & ~bvalid_reg;
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;
  assign S_AXI_ARREADY = ~rvalid_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_reg;

endmodule : timer_two_control_logic

// ===== tb/timer_two_control_logic_asserts.sv
`timescale 1ns/10ps
module timer_two_checker
  import timer_two_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [1:0] SERIAL_MODE,
  input wire logic RX_BAUD_TICK,
  input wire logic TX_BAUD_TICK
);
  // ------------------------------
  // Port checks
  // ------------------------------
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  // Only modes 1 and 3 take a baud clock, so ticks elsewhere are a leak
  logic timed;
  assign timed = (SERIAL_MODE == SERIAL_MODE_ONE) || (SERIAL_MODE == SERIAL_MODE_THREE);
  sequence s_write_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence s_write_answer;
    ##[1:2] S_AXI_BVALID;
  endsequence
  property p_rx_gate;
    !timed |-> !RX_BAUD_TICK;
  endproperty
  a_rx_gate: assert property (p_rx_gate) else $error("receive tick outside timed modes");
  property p_tx_gate;
    !timed |-> !TX_BAUD_TICK;
  endproperty
  a_tx_gate: assert property (p_tx_gate) else $error("transmit tick outside timed modes");
  property p_write_answer;
    s_write_taken |-> s_write_answer;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write response late");
  property p_write_block;
    S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY;
  endproperty
  a_write_block: assert property (p_write_block) else $error("write taken under pending response");
  property p_read_block;
    S_AXI_RVALID |-> !S_AXI_ARREADY;
  endproperty
  a_read_block: assert property (p_read_block) else $error("read taken under pending data");
  property p_read_answer;
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read data late");
  property p_b_clear;
    S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID;
  endproperty
  a_b_clear: assert property (p_b_clear) else $error("write response not released");
  property p_r_clear;
    S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID;
  endproperty
  a_r_clear: assert property (p_r_clear) else $error("read data not released");
endmodule : timer_two_checker
bind timer_two_control_logic timer_two_checker timer_two_checker_inst (
  .CLOCK(CLOCK), .RESET_N(RESET_N), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .SERIAL_MODE(SERIAL_MODE),
  .RX_BAUD_TICK(RX_BAUD_TICK), .TX_BAUD_TICK(TX_BAUD_TICK)
);

// ===== tb/timer_two_neighbours.sv
`timescale 1ns/10ps
module timer_two_neighbours (
  input wire logic CLOCK,
  input wire logic RX_BAUD_TICK,
  input wire logic TX_BAUD_TICK,
  output logic TRIGGER_INPUT,
  output logic EVENT_INPUT,
  output logic TIMER1_OVERFLOW
);
  int rx_ticks = 0;
  int tx_ticks = 0;
  // Pins sit on pull-ups, so they idle high between events
  initial begin
    TRIGGER_INPUT = 1'b1;
    EVENT_INPUT = 1'b1;
    TIMER1_OVERFLOW = 1'b0;
  end
  // Serial port side counts every tick it is handed
  always @(posedge CLOCK) begin
    rx_ticks <= rx_ticks + int'(RX_BAUD_TICK === 1'b1);
    tx_ticks <= tx_ticks + int'(TX_BAUD_TICK === 1'b1);
  end
  // Counts are zeroed between edges so no tick update races the clear
  task automatic clear_ticks;
    @(negedge CLOCK);
    rx_ticks = 0;
    tx_ticks = 0;
    @(posedge CLOCK);
  endtask : clear_ticks
  // Low long enough for the synchroniser, then back to idle
  task automatic pin_fall(input logic trig);
    @(posedge CLOCK);
    TRIGGER_INPUT <= !trig;
    EVENT_INPUT <= trig;
    repeat (4) @(posedge CLOCK);
    TRIGGER_INPUT <= 1'b1;
    EVENT_INPUT <= 1'b1;
    repeat (4) @(posedge CLOCK);
  endtask : pin_fall
  // Other timer overflows, one-cycle pulses spaced apart
  task automatic t1_burst(input int n);
    repeat (n) begin
      @(posedge CLOCK);
      TIMER1_OVERFLOW <= 1'b1;
      @(posedge CLOCK);
      TIMER1_OVERFLOW <= 1'b0;
      repeat (3) @(posedge CLOCK);
    end
  endtask : t1_burst
endmodule : timer_two_neighbours

// ===== tb/test_timer2_control_logic.sv
`timescale 1ns/10ps
module test_timer2_control_logic import timer_two_pkg::*;;
  logic clock = 1'b0;
  logic reset_n;
  logic [7:0] awaddr;
  logic [7:0] araddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [1:0] serial_mode;
  logic awready, wready, bvalid, arready, rvalid, trig, evt, t1ovf, rx_tick, tx_tick, int_req, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int n_errors = 0;
  int checks = 0;
  // Short tick divide keeps overflow runs brief
  always #5 clock = ~clock;
  timer_two_control_logic #(.TICK_DIVIDE(2)) timer_two_control_logic_inst (
    .CLOCK(clock), .RESET_N(reset_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .TRIGGER_INPUT(trig),
    .EVENT_INPUT(evt), .TIMER1_OVERFLOW(t1ovf), .SERIAL_MODE(serial_mode), .RX_BAUD_TICK(rx_tick),
    .TX_BAUD_TICK(tx_tick), .TIMER_INT_REQ(int_req), .IRQ(irq)
  );
  timer_two_neighbours timer_two_neighbours_inst (
    .CLOCK(clock), .RX_BAUD_TICK(rx_tick), .TX_BAUD_TICK(tx_tick),
    .TRIGGER_INPUT(trig), .EVENT_INPUT(evt), .TIMER1_OVERFLOW(t1ovf)
  );
  // ------------------------------
  // Bus and check tasks
  // ------------------------------
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // A spent wait bound is a hang: report and stop
  task automatic guard(input int n);
    if (n >= 300) begin
      n_errors++;
      $display("unexpected handshake expected answer seen none");
      tally_and_finish();
    end
  endtask : guard
  // Readiness is looked at mid-cycle, where it equals what the next edge samples
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY,
                    input logic [3:0] s = 4'hF);
    int n;
    logic at, wt, ad, wd;
    n = 0;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd) && n < 300) begin
      @(negedge clock);
      at = awvalid && awready === 1'b1;
      wt = wvalid && wready === 1'b1;
      @(posedge clock);
      if (at) awvalid <= 1'b0;
      if (wt) wvalid <= 1'b0;
      ad = ad | at;
      wd = wd | wt;
      n++;
    end
    while (bvalid !== 1'b1 && n < 300) begin
      @(negedge clock);
      n++;
    end
    check("write response", bresp, er);
    @(posedge clock);
    bready <= 1'b0;
    @(posedge clock);
    guard(n);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
    int n;
    logic at;
    n = 0;
    at = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!at && n < 300) begin
      @(negedge clock);
      at = arready === 1'b1;
      @(posedge clock);
      n++;
    end
    arvalid <= 1'b0;
    while (rvalid !== 1'b1 && n < 300) begin
      @(negedge clock);
      n++;
    end
    check("read data", rdata, e);
    check("read response", rresp, er);
    @(posedge clock);
    rready <= 1'b0;
    @(posedge clock);
    guard(n);
  endtask : rc
  task automatic wait_req;
    int n;
    n = 0;
    while (int_req !== 1'b1 && n < 300) begin
      @(negedge clock);
      n++;
    end
    guard(n);
    @(posedge clock);
  endtask : wait_req
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    reset_n <= 1'b0;
    awaddr <= 8'h00;
    araddr <= 8'h00;
    wdata <= 32'h0;
    wstrb <= 4'hF;
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b0;
    arvalid <= 1'b0;
    rready <= 1'b0;
    serial_mode <= 2'h0;
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    rc(ADDR_CONTROL, 32'h0);
    rc(ADDR_RELOAD_HIGH, 32'h0);
    rc(8'h1C, 32'h0, RESP_SLVERR);
    wr(8'h1C, 32'hFF, RESP_SLVERR);
    // Flags written by software drive the request
    wr(ADDR_CONTROL, 32'hC0);
    rc(ADDR_CONTROL, 32'hC0);
    wr(ADDR_CONTROL, 32'h40);
    check("request", int_req, 1'b1);
    wr(ADDR_MODE, 32'h1);
    check("request", int_req, 1'b0);
    wr(ADDR_CONTROL, 32'h80);
    check("request", int_req, 1'b1);
    wr(ADDR_MODE, 32'h0);
    wr(ADDR_CONTROL, 32'h00);
    check("request", int_req, 1'b0);
    // Halted timer holds, a write with no lane strobe changes nothing
    wr(ADDR_RELOAD_LOW, 32'h34);
    wr(ADDR_RELOAD_HIGH, 32'h12);
    wr(ADDR_COUNT, 32'hFFFF);
    wr(ADDR_COUNT, 32'h0000, RESP_OKAY, 4'h0);
    repeat (20) @(posedge clock);
    rc(ADDR_COUNT, 32'hFFFF);
    wr(ADDR_CONTROL, 32'h04);
    wait_req();
    wr(ADDR_CONTROL, 32'h06);
    wr(ADDR_COUNT, 32'hFFFE);
    repeat (2) timer_two_neighbours_inst.pin_fall(1'b0);
    rc(ADDR_COUNT, 32'h1234);
    rc(ADDR_CONTROL, 32'h86);
    wr(ADDR_IRQ_MASK, 32'h1);
    check("irq", irq, 1'b1);
    wr(ADDR_IRQ_STATUS, 32'h1);
    check("irq", irq, 1'b0);
    wr(ADDR_CONTROL, 32'h07);
    wr(ADDR_COUNT, 32'hFFFF);
    timer_two_neighbours_inst.pin_fall(1'b0);
    rc(ADDR_COUNT, 32'h0);
    // Trigger edge: capture, ignore, baud-blocked, reload
    wr(ADDR_CONTROL, 32'h09);
    wr(ADDR_COUNT, 32'h5A5A);
    timer_two_neighbours_inst.pin_fall(1'b1);
    wait_req();
    rc(ADDR_RELOAD_LOW, 32'h5A);
    rc(ADDR_CONTROL, 32'h49);
    wr(ADDR_CONTROL, 32'h01);
    wr(ADDR_COUNT, 32'h0077);
    timer_two_neighbours_inst.pin_fall(1'b1);
    rc(ADDR_CONTROL, 32'h01);
    rc(ADDR_RELOAD_LOW, 32'h5A);
    wr(ADDR_CONTROL, 32'h39);
    timer_two_neighbours_inst.pin_fall(1'b1);
    rc(ADDR_CONTROL, 32'h39);
    rc(ADDR_RELOAD_HIGH, 32'h5A);
    wr(ADDR_CONTROL, 32'h08);
    timer_two_neighbours_inst.pin_fall(1'b1);
    wait_req();
    rc(ADDR_COUNT, 32'h5A5A);
    // Baud source in both timed modes, capture select overridden
    wr(ADDR_RELOAD_LOW, 32'hF0);
    wr(ADDR_RELOAD_HIGH, 32'hFF);
    for (int i = 0; i < 2; i++) begin
      serial_mode <= i ? SERIAL_MODE_THREE : SERIAL_MODE_ONE;
      wr(ADDR_COUNT, 32'hFFF0);
      timer_two_neighbours_inst.clear_ticks();
      wr(ADDR_CONTROL, 32'h35);
      repeat (100) @(posedge clock);
      wr(ADDR_CONTROL, 32'h31);
      // A wrap to zero would give one tick only; the forced reload gives several
      check("receive ticks above one", timer_two_neighbours_inst.rx_ticks > 1, 1'b1);
      check("transmit ticks", timer_two_neighbours_inst.tx_ticks, timer_two_neighbours_inst.rx_ticks);
      rc(ADDR_CONTROL, 32'h31);
    end
    // Each direction alone on the other timer
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_CONTROL, i ? 32'h10 : 32'h20);
      timer_two_neighbours_inst.clear_ticks();
      timer_two_neighbours_inst.t1_burst(5);
      check("receive ticks", timer_two_neighbours_inst.rx_ticks, i ? 5 : 0);
      check("transmit ticks", timer_two_neighbours_inst.tx_ticks, i ? 0 : 5);
    end
    // Outside the timed serial modes no tick reaches either direction
    serial_mode <= 2'h2;
    wr(ADDR_CONTROL, 32'h00);
    timer_two_neighbours_inst.clear_ticks();
    timer_two_neighbours_inst.t1_burst(3);
    check("receive ticks untimed", timer_two_neighbours_inst.rx_ticks, 0);
    check("transmit ticks untimed", timer_two_neighbours_inst.tx_ticks, 0);
    tally_and_finish();
  end
endmodule : test_timer2_control_logic
